// file: verilog/pole_freq_tone_check.sv
// Per-frame pole frequency check deciding whether a frame can be ruled
// out as an information tone or must go on to the prediction error test.
// Assumes the analysis stage on the same clock presents the first two
// unquantized reflection coefficients with a one-cycle strobe per frame.
//
// Behaviour
// (R1) Second-order filter coefficients come only from the first two reflection coefficients, leading coefficient one.
// (R2) Real term is minus half the first coefficient; imaginary term is (4*a2 - a1^2)/4.
// (R3) A negative imaginary term means real poles, so the frame is not a tone and the check ends.
// (R4) A real term that is not positive asks for the prediction error test.
// (R5) With both terms positive the numerator over a1 squared is compared with the 385 Hz limit 0.0973.
// (R6) If that comparison holds the frame is not a tone, otherwise the prediction error test is asked for.
// (R7) Zero terms count as not positive, the ratio is cross-multiplied, and one result strobe comes per frame; a frame offered while busy is dropped.
`timescale 1ns/10ps
module pole_freq_tone_check
  import pole_tone_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_valid,
  input wire logic signed [RC_W-1:0] reflect_coef_1,
  input wire logic signed [RC_W-1:0] reflect_coef_2,
  output logic busy,
  output logic result_valid,
  output logic not_tone,
  output logic run_pred_test,
  output logic signed [A1_W-1:0] pole_real_term,
  output logic signed [NUM_W-1:0] pole_imag_sq_term
);

  // ---------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------
  check_state_t state_r;
  check_state_t state_nxt;
  logic signed [RC_W-1:0] rc1_r;
  logic signed [RC_W-1:0] rc2_r;
  logic signed [A1_W-1:0] coef1_r;
  logic signed [RC_W-1:0] coef2_r;
  logic signed [A1_W-1:0] real_r;
  logic signed [NUM_W-1:0] num_r;
  logic signed [SQ_W-1:0] sq_r;
  logic result_valid_r;
  logic not_tone_r;
  logic run_pred_test_r;
  logic busy_r;
  logic signed [A1_W-1:0] real_out_r;
  logic signed [NUM_W-1:0] imag_out_r;

  // ---------------------------------------------------------------
  // Coefficient and term arithmetic
  // ---------------------------------------------------------------
  logic signed [2*RC_W-1:0] rc_prod;
  logic signed [2*RC_W-1:0] rc_prod_q15;
  logic signed [A1_W-1:0] coef1_nxt;
  logic signed [SQ_W-1:0] sq_nxt;
  logic signed [NUM_W-1:0] a2_scaled;
  logic signed [NUM_W-1:0] num_nxt;
  logic signed [A1_W-1:0] real_nxt;
  logic start;
  logic imag_neg;
  logic imag_pos;
  logic real_pos;
  logic ratio_below;
  logic not_tone_nxt;

  assign start = (state_r == S_IDLE) && frame_valid;

  // a[1] = rc1 * (1 + rc2), a[2] = rc2, a[0] = 1 implied
  assign rc_prod = rc1_r * rc2_r; // R1
  assign rc_prod_q15 = rc_prod >>> Q15_SHIFT;
  assign coef1_nxt = A1_W'(rc1_r) + rc_prod_q15[A1_W-1:0]; // R1

  assign real_nxt = -(coef1_r >>> HALF_SHIFT); // R2
  assign sq_nxt = SQ_W'(coef1_r) * SQ_W'(coef1_r);
  assign a2_scaled = NUM_W'(coef2_r) <<< A2_TO_NUM_SHIFT;
  // Kept at four times the imaginary term so no precision is lost
  assign num_nxt = a2_scaled - NUM_W'(sq_nxt); // R2

  assign imag_neg = num_r < 0; // R3
  assign imag_pos = num_r > 0; // R7
  assign real_pos = real_r > 0; // R7

  pole_ratio_cmp ratio_cmp
  (
    .num(num_r),
    .sq(sq_r),
    .below(ratio_below)
  );

  // Real poles first, then the left half plane, then the 385 Hz test
  assign not_tone_nxt = imag_neg ? 1'b1 : // R3
                        (!real_pos || !imag_pos) ? 1'b0 : // R4
                        ratio_below; // R5 R6

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  always_comb
  begin
    case (state_r)
      S_IDLE:
        state_nxt = frame_valid ? S_COEF : S_IDLE;
      S_COEF:
        state_nxt = S_TERMS;
      S_TERMS:
        state_nxt = S_DECIDE;
      S_DECIDE:
        state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= S_IDLE;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      // Registered copy so the busy pin comes from a flip-flop
      busy_r <= state_nxt != S_IDLE;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rc1_r <= '0;
      rc2_r <= '0;
    end
    else if (start)
    begin
      rc1_r <= reflect_coef_1; // R1
      rc2_r <= reflect_coef_2; // R1
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      coef1_r <= '0;
      coef2_r <= '0;
    end
    else if (state_r == S_COEF)
    begin
      coef1_r <= coef1_nxt;
      coef2_r <= rc2_r;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      real_r <= '0;
      num_r <= '0;
      sq_r <= '0;
    end
    else if (state_r == S_TERMS)
    begin
      real_r <= real_nxt;
      num_r <= num_nxt;
      sq_r <= sq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Result strobe for one cycle; outcome and terms held until the next frame's decision
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      result_valid_r <= 1'b0;
    else
      result_valid_r <= state_r == S_DECIDE; // R7
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      not_tone_r <= 1'b0;
      run_pred_test_r <= 1'b0;
      real_out_r <= '0;
      imag_out_r <= '0;
    end
    else if (state_r == S_DECIDE)
    begin
      not_tone_r <= not_tone_nxt; // R6
      run_pred_test_r <= !not_tone_nxt; // R4 R6
      real_out_r <= real_r;
      imag_out_r <= num_r >>> QUARTER_SHIFT; // R2
    end
  end

  assign busy = busy_r;
  assign result_valid = result_valid_r;
  assign not_tone = not_tone_r;
  assign run_pred_test = run_pred_test_r;
  assign pole_real_term = real_out_r;
  assign pole_imag_sq_term = imag_out_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic signed [PROD_W-1:0] chk_lhs;
  logic signed [PROD_W-1:0] chk_rhs;
  assign chk_lhs = PROD_W'(num_r) * PROD_W'(RATIO_DEN);
  assign chk_rhs = PROD_W'(sq_r) * PROD_W'(RATIO_NUM);

  coef_from_rc_a: assert property ( // R1
    start ##1 1'b1 |=> coef2_r == $past(reflect_coef_2, 2)
  ) else $error("second coefficient not taken from rc2");

  terms_formed_a: assert property ( // R2
    state_r == S_TERMS |=>
      real_r == -($past(coef1_r) >>> HALF_SHIFT) &&
      num_r == (NUM_W'($past(coef2_r)) <<< A2_TO_NUM_SHIFT) -
               NUM_W'(SQ_W'($past(coef1_r)) * SQ_W'($past(coef1_r)))
  ) else $error("pole terms wrong");

  real_poles_a: assert property ( // R3
    state_r == S_DECIDE && num_r < 0 |=>
      result_valid && not_tone && !run_pred_test
  ) else $error("real poles not flagged as no tone");

  left_half_a: assert property ( // R4
    state_r == S_DECIDE && num_r >= 0 && real_r <= 0 |=>
      result_valid && run_pred_test && !not_tone
  ) else $error("left half plane did not request error test");

  low_freq_a: assert property ( // R5
    state_r == S_DECIDE && num_r > 0 && real_r > 0 |=>
      not_tone == (chk_lhs < chk_rhs)
  ) else $error("385 Hz comparison wrong");

  outcome_excl_a: assert property ( // R6
    result_valid |-> not_tone != run_pred_test
  ) else $error("both or neither outcome given");

  one_strobe_a: assert property ( // R7
    start |-> ##4 result_valid ##1 (!result_valid)[*2]
  ) else $error("result strobe not one per frame");

  zero_real_a: assert property ( // R7
    state_r == S_DECIDE && num_r > 0 && real_r == 0 |=> run_pred_test
  ) else $error("zero real term treated as positive");

endmodule

// file: verilog/pole_tone_pkg.sv
// Constants shared by the pole frequency tone check and its comparator.
// Assumes reflection coefficients arrive as signed Q15 words.
package pole_tone_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int RC_W = 16;
  localparam int A1_W = 18;
  localparam int SQ_W = 36;
  localparam int NUM_W = 37;
  localparam int PROD_W = 54;

  // ---------------------------------------------------------------
  // Fixed point scaling
  // ---------------------------------------------------------------
  localparam int Q15_SHIFT = 15;
  // Moves a Q15 value to Q30 and multiplies it by four
  localparam int A2_TO_NUM_SHIFT = 17;
  localparam int HALF_SHIFT = 1;
  localparam int QUARTER_SHIFT = 2;

  // ---------------------------------------------------------------
  // Low frequency limit, tan^2 of a 385 Hz pole as 973 / 10000
  // ---------------------------------------------------------------
  localparam logic signed [15:0] RATIO_NUM = 16'sh03cd;
  localparam logic signed [15:0] RATIO_DEN = 16'sh2710;

  // ---------------------------------------------------------------
  // Check sequence
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    S_IDLE = 2'b00,
    S_COEF = 2'b01,
    S_TERMS = 2'b10,
    S_DECIDE = 2'b11
  } check_state_t;

  localparam int RESULT_LATENCY = 3;

endpackage

// file: verilog/pole_ratio_cmp.sv
// Cross-multiplied ratio comparator for the low frequency pole test.
// Assumes sq is non-negative; the caller only uses the result when
// both pole terms are positive.
`timescale 1ns/10ps
module pole_ratio_cmp
  import pole_tone_pkg::*;
(
  input wire logic signed [NUM_W-1:0] num,
  input wire logic signed [SQ_W-1:0] sq,
  output logic below
);

  logic signed [PROD_W-1:0] lhs;
  logic signed [PROD_W-1:0] rhs;

  // num / sq < RATIO_NUM / RATIO_DEN without any division
  assign lhs = PROD_W'(num) * PROD_W'(RATIO_DEN);
  assign rhs = PROD_W'(sq) * PROD_W'(RATIO_NUM);
  assign below = lhs < rhs;

endmodule

// file: testbench/coef_source.sv
// Behavioural analysis stage presenting reflection coefficients.
// Assumes the bench raises send for one cycle per frame.
`timescale 1ns/10ps
module coef_source
  import pole_tone_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic send,
  input wire logic [RC_W-1:0] c1,
  input wire logic [RC_W-1:0] c2,
  output logic frame_valid,
  output logic signed [RC_W-1:0] reflect_coef_1,
  output logic signed [RC_W-1:0] reflect_coef_2
);
  // Outside the strobe the words are not valid, so they toggle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      frame_valid <= 1'b0;
      reflect_coef_1 <= 16'h0000;
      reflect_coef_2 <= 16'h0000;
    end
    else
    begin
      frame_valid <= send;
      reflect_coef_1 <= send ? c1 : ~reflect_coef_1;
      reflect_coef_2 <= send ? c2 : ~reflect_coef_2;
    end
  end
endmodule

// file: testbench/pole_freq_tone_check_tb_top.sv
// Self-checking bench for the pole frequency tone check.
// Assumes the coefficient source model and the design package.
`timescale 1ns/10ps
module pole_freq_tone_check_tb_top
  import pole_tone_pkg::*;
;
  typedef struct packed
  {
    logic [15:0] c1;
    logic [15:0] c2;
    logic nt;
  } row_t;
  row_t rows [6] = '{'{16'h4000, 16'h0000, 1'b1},
    '{16'hc000, 16'h7000, 1'b0}, '{16'h4000, 16'h7000, 1'b0},
    '{16'h851f, 16'h6000, 1'b1}, '{16'h0000, 16'h0000, 1'b0},
    '{16'h0000, 16'h2000, 1'b0}};
  logic clk, reset, send, frame_valid, busy, result_valid;
  logic not_tone, run_pred_test;
  logic [RC_W-1:0] c1, c2;
  logic signed [RC_W-1:0] reflect_coef_1, reflect_coef_2;
  logic signed [A1_W-1:0] pole_real_term;
  logic signed [NUM_W-1:0] pole_imag_sq_term;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  coef_source src (.clk(clk), .reset(reset), .send(send), .c1(c1),
    .c2(c2), .frame_valid(frame_valid), .reflect_coef_1(reflect_coef_1),
    .reflect_coef_2(reflect_coef_2));
  pole_freq_tone_check dut (.clk(clk), .reset(reset),
    .frame_valid(frame_valid), .reflect_coef_1(reflect_coef_1),
    .reflect_coef_2(reflect_coef_2), .busy(busy),
    .result_valid(result_valid), .not_tone(not_tone),
    .run_pred_test(run_pred_test), .pole_real_term(pole_real_term),
    .pole_imag_sq_term(pole_imag_sq_term));

  // ---------------------------------------------------------------
  // Checking tasks
  // ---------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_term(input logic [NUM_W-1:0] got,
    input logic [NUM_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic result(input logic signed [15:0] a, b, input logic nt);
    logic signed [31:0] p;
    logic signed [A1_W-1:0] a1;
    logic signed [NUM_W-1:0] n;
    p = 32'(a) * 32'(b);
    a1 = 18'(a) + 18'(p >>> 15);
    n = (37'(b) <<< 17) - 37'(a1) * 37'(a1);
    chk_bit(result_valid, 1'b1);
    chk_bit(busy, 1'b0);
    chk_bit(not_tone, nt);
    chk_bit(run_pred_test, ~nt);
    chk_term(NUM_W'(pole_real_term), NUM_W'(-(a1 >>> 1)));
    chk_term(pole_imag_sq_term, n >>> 2);
  endtask

  task automatic kick(input logic [15:0] a, b);
    send <= 1'b1;
    c1 <= a;
    c2 <= b;
    @(posedge clk);
    send <= 1'b0;
  endtask

  task automatic frame(input logic [15:0] a, b, input logic nt);
    @(posedge clk);
    kick(a, b);
    @(posedge clk);
    #1 chk_bit(busy, 1'b1);
    repeat (3) @(posedge clk);
    #1 result(a, b, nt);
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock and timeout
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    send = 1'b0;
    c1 = 16'h0000;
    c2 = 16'h0000;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk_bit(not_tone | run_pred_test | result_valid, 1'b0);
    $display("reset test done");
    foreach (rows[i])
      frame(rows[i].c1, rows[i].c2, rows[i].nt);
    $display("table test done");
    // Next frame arrives in the result cycle
    @(posedge clk);
    kick(rows[2].c1, rows[2].c2);
    repeat (3) @(posedge clk);
    kick(rows[3].c1, rows[3].c2);
    #1 result(rows[2].c1, rows[2].c2, 1'b0);
    @(posedge clk);
    #1 chk_bit(busy, 1'b1);
    repeat (3) @(posedge clk);
    #1 result(rows[3].c1, rows[3].c2, 1'b1);
    $display("back to back test done");
    // A frame offered while busy is dropped
    @(posedge clk);
    kick(rows[0].c1, rows[0].c2);
    @(posedge clk);
    kick(rows[1].c1, rows[1].c2);
    repeat (2) @(posedge clk);
    #1 result(rows[0].c1, rows[0].c2, 1'b1);
    repeat (4)
    begin
      @(posedge clk);
      #1 chk_bit(result_valid, 1'b0);
    end
    chk_bit(not_tone, 1'b1);
    $display("refused frame test done");
    @(posedge clk);
    reset <= 1'b1;
    #1 chk_bit(not_tone | run_pred_test, 1'b0);
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk_bit(busy | result_valid, 1'b0);
    frame(rows[3].c1, rows[3].c2, rows[3].nt);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
